// ### shared/port_gate_regs.svh
`ifndef PORT_GATE_REGS_SVH
`define PORT_GATE_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RUN_CLOCK_CONFIG_OFF 12'h060
`define RUN_PORT_GATE_OFF 12'h108
`define SLEEP_PORT_GATE_OFF 12'h118
`define DEEP_PORT_GATE_OFF 12'h128
`define INT_STATUS_OFF 12'h200
`define INT_MASK_OFF 12'h204

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define PORT_COUNT 8
`define AUTO_CLOCK_GATING_BIT 27
`define INT_BUS_FAULT_BIT 0
`define INT_POWER_CHANGE_BIT 1
`define INT_WIDTH 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PORT_GATE_RESET 8'h00
`define RUN_CLOCK_CONFIG_RESET 1'b0
`define INT_RESET 2'h0
`define WORD_ZERO 32'h0000_0000

`endif

// ### shared/port_gate_pkg.sv
package port_gate_pkg;

   typedef enum logic [1:0] {
      PS_RUN,
      PS_SLEEP,
      PS_DEEP
   } power_state_e;

   typedef logic [7:0] port_mask_t;

endpackage

// ### design/port_fault_check.sv
`timescale 1ns/1ps
`include "port_gate_regs.svh"

module port_fault_check
   import port_gate_pkg::*;
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic acc_valid, // A port access is presented this cycle.
   input wire logic [2:0] acc_port, // Port index of that access.
   input wire port_mask_t gate_en, // Current port clock enables.
   output logic fault_pulse, // One-cycle bus fault answer.
   output logic [2:0] fault_port // Port that caused the last fault.
);

   logic fault_next;
   logic [2:0] fault_port_next;

   // An access to a stopped port cannot complete, so it is answered with a fault.
   always_comb begin
      fault_next = acc_valid && !gate_en[acc_port];
      fault_port_next = fault_port;
      if (fault_next) begin
         fault_port_next = acc_port;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_pulse <= 1'b0;
         fault_port <= 3'h0;
      end else begin
         fault_pulse <= fault_next;
         fault_port <= fault_port_next;
      end
   end

endmodule

// ### design/port_gate_ctrl.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "port_gate_regs.svh"

module port_gate_ctrl
   import port_gate_pkg::*;
(
   input wire logic pclk, // System clock, 50 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic sleep_active, // Core is in sleep.
   input wire logic deep_sleep_active, // Core is in deep sleep.
   input wire logic port_acc_valid, // Bus access to a port this cycle.
   input wire logic [2:0] port_acc_sel, // Index of the accessed port.
   output port_mask_t port_clk_en, // Clock enable per port.
   output logic bus_fault, // Fault answer for a port access.
   output logic [2:0] fault_port, // Port of the last fault.
   output logic irq // Level interrupt.
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   port_mask_t run_gate_reg, run_gate_next;
   port_mask_t sleep_gate_reg, sleep_gate_next;
   port_mask_t deep_gate_reg, deep_gate_next;
   logic auto_gate_reg, auto_gate_next;
   logic [`INT_WIDTH-1:0] int_status_reg, int_status_next;
   logic [`INT_WIDTH-1:0] int_mask_reg, int_mask_next;
   power_state_e power_state_reg, power_state_next;
   port_mask_t clk_en_reg, clk_en_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;
   logic [11:0] addr_word;
   logic addr_hit;
   logic wr_take;
   logic [`INT_WIDTH-1:0] int_events;
   logic fault_pulse;
   port_mask_t sel_gate;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign port_clk_en = clk_en_reg;
   assign irq = irq_reg;
   assign bus_fault = fault_pulse;
   assign addr_word = {paddr[11:2], 2'b00};

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Ready is registered from the setup cycle, so every transfer has exactly one
   // access cycle; this keeps all bus outputs coming from flip-flops.
   always_comb begin
      addr_hit = 1'b0;
      prdata_next = `WORD_ZERO;
      case (addr_word)
         `RUN_CLOCK_CONFIG_OFF: begin
            addr_hit = 1'b1;
            prdata_next[`AUTO_CLOCK_GATING_BIT] = auto_gate_reg;
         end
         `RUN_PORT_GATE_OFF: begin
            addr_hit = 1'b1;
            prdata_next[7:0] = run_gate_reg;
         end
         `SLEEP_PORT_GATE_OFF: begin
            addr_hit = 1'b1;
            prdata_next[7:0] = sleep_gate_reg;
         end
         `DEEP_PORT_GATE_OFF: begin
            addr_hit = 1'b1;
            prdata_next[7:0] = deep_gate_reg;
         end
         `INT_STATUS_OFF: begin
            addr_hit = 1'b1;
            prdata_next[`INT_WIDTH-1:0] = int_status_reg;
         end
         `INT_MASK_OFF: begin
            addr_hit = 1'b1;
            prdata_next[`INT_WIDTH-1:0] = int_mask_reg;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
      pready_next = psel && !penable;
      pslverr_next = psel && !penable && !addr_hit;
      if (!(psel && !penable) || pwrite) begin
         prdata_next = `WORD_ZERO;
      end
      wr_take = psel && penable && pready_reg && pwrite && addr_hit;
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_comb begin
      run_gate_next = run_gate_reg;
      sleep_gate_next = sleep_gate_reg;
      deep_gate_next = deep_gate_reg;
      auto_gate_next = auto_gate_reg;
      int_mask_next = int_mask_reg;
      int_status_next = int_status_reg;
      if (wr_take) begin
         case (addr_word)
            `RUN_CLOCK_CONFIG_OFF: begin
               auto_gate_next = pwdata[`AUTO_CLOCK_GATING_BIT];
            end
            `RUN_PORT_GATE_OFF: begin
               run_gate_next = pwdata[7:0];
            end
            `SLEEP_PORT_GATE_OFF: begin
               sleep_gate_next = pwdata[7:0];
            end
            `DEEP_PORT_GATE_OFF: begin
               deep_gate_next = pwdata[7:0];
            end
            `INT_STATUS_OFF: begin
               int_status_next = int_status_reg & ~pwdata[`INT_WIDTH-1:0];
            end
            `INT_MASK_OFF: begin
               int_mask_next = pwdata[`INT_WIDTH-1:0];
            end
            default: begin
               int_mask_next = int_mask_reg;
            end
         endcase
      end
      // A new event in the same cycle as its clear keeps the bit set.
      int_status_next = int_status_next | int_events;
      irq_next = |(int_status_next & int_mask_next);
   end

   // ----------------------------------------
   // Power state and port clock selection
   // ----------------------------------------
   always_comb begin
      case ({deep_sleep_active, sleep_active})
         2'b10, 2'b11: power_state_next = PS_DEEP;
         2'b01: power_state_next = PS_SLEEP;
         default: power_state_next = PS_RUN;
      endcase
      int_events = '0;
      int_events[`INT_BUS_FAULT_BIT] = fault_pulse;
      int_events[`INT_POWER_CHANGE_BIT] = power_state_next != power_state_reg;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `PORT_COUNT; gi++) begin : g_port
         // Without auto gating the run register governs every state.
         always_comb begin
            sel_gate[gi] = run_gate_reg[gi];
            if (auto_gate_reg) begin
               case (power_state_reg)
                  PS_DEEP: sel_gate[gi] = deep_gate_reg[gi];
                  PS_SLEEP: sel_gate[gi] = sleep_gate_reg[gi];
                  default: sel_gate[gi] = run_gate_reg[gi];
               endcase
            end
            clk_en_next[gi] = sel_gate[gi];
         end
      end
   endgenerate

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_gate_reg <= `PORT_GATE_RESET;
         sleep_gate_reg <= `PORT_GATE_RESET;
         deep_gate_reg <= `PORT_GATE_RESET;
         auto_gate_reg <= `RUN_CLOCK_CONFIG_RESET;
         int_status_reg <= `INT_RESET;
         int_mask_reg <= `INT_RESET;
         power_state_reg <= PS_RUN;
         clk_en_reg <= `PORT_GATE_RESET;
         prdata_reg <= `WORD_ZERO;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         run_gate_reg <= run_gate_next;
         sleep_gate_reg <= sleep_gate_next;
         deep_gate_reg <= deep_gate_next;
         auto_gate_reg <= auto_gate_next;
         int_status_reg <= int_status_next;
         int_mask_reg <= int_mask_next;
         power_state_reg <= power_state_next;
         clk_en_reg <= clk_en_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
      end
   end

   // ----------------------------------------
   // Fault answer for gated ports
   // ----------------------------------------
   // The check uses the enables already driven to the ports, so a port is
   // faulted for exactly as long as its clock is really stopped.
   port_fault_check u_fault (
      .pclk(pclk),
      .presetn(presetn),
      .acc_valid(port_acc_valid),
      .acc_port(port_acc_sel),
      .gate_en(clk_en_reg),
      .fault_pulse(fault_pulse),
      .fault_port(fault_port)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_deep_select;
      (auto_gate_reg && power_state_reg == PS_DEEP) |=> clk_en_reg == $past(deep_gate_reg);
   endproperty
   a_deep_select: assert property (p_deep_select)
      else $error("deep sleep does not use the deep-sleep gating register");

   property p_run_without_auto;
      !auto_gate_reg |=> clk_en_reg == $past(run_gate_reg);
   endproperty
   a_run_without_auto: assert property (p_run_without_auto)
      else $error("run register not used while auto gating is off");

   property p_fault_gated;
      (port_acc_valid && !clk_en_reg[port_acc_sel])
         |=> bus_fault && fault_port == $past(port_acc_sel);
   endproperty
   a_fault_gated: assert property (p_fault_gated)
      else $error("access to a stopped port was not faulted");

   property p_no_fault_clocked;
      (port_acc_valid && clk_en_reg[port_acc_sel]) |=> !bus_fault;
   endproperty
   a_no_fault_clocked: assert property (p_no_fault_clocked)
      else $error("access to a clocked port was faulted");

   property p_reserved_zero;
      (psel && !penable && !pwrite && addr_word == `DEEP_PORT_GATE_OFF)
         |=> pready && prdata[31:8] == 24'h00_0000 && prdata[7:0] == deep_gate_reg;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("deep-sleep register read is wrong or reserved bits not zero");

   property p_write_low_byte;
      (psel && penable && pready && pwrite && addr_word == `DEEP_PORT_GATE_OFF)
         |=> deep_gate_reg == $past(pwdata[7:0]);
   endproperty
   a_write_low_byte: assert property (p_write_low_byte)
      else $error("deep-sleep register did not take the written low byte");

   property p_reset_clear;
      $rose(presetn) |-> deep_gate_reg == 8'h00 && clk_en_reg == 8'h00;
   endproperty
   a_reset_clear: assert property (@(posedge pclk) p_reset_clear)
      else $error("register not clear after reset");

   property p_fault_sticky;
      bus_fault |=> int_status_reg[`INT_BUS_FAULT_BIT] ##1 (int_status_reg[`INT_BUS_FAULT_BIT]
         || $past(wr_take && addr_word == `INT_STATUS_OFF
         && pwdata[`INT_BUS_FAULT_BIT]));
   endproperty
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("bus fault did not set the sticky status bit");

   property p_ready_one_cycle;
      pready |=> !pready;
   endproperty
   a_ready_one_cycle: assert property (p_ready_one_cycle)
      else $error("ready held longer than one cycle");

   c_fault: cover property (port_acc_valid ##1 bus_fault);
   c_deep_entry: cover property (auto_gate_reg && power_state_reg == PS_DEEP
      && deep_gate_reg != 8'h00);
   c_irq: cover property ($rose(irq));
   c_unmapped: cover property (pslverr);

endmodule

// ### tb/port_gate_ctrl_tb.sv
`timescale 1ns/1ps
`include "port_gate_regs.svh"

module port_gate_ctrl_tb
   import port_gate_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleep_active;
   logic deep_sleep_active;
   logic port_acc_valid;
   logic [2:0] port_acc_sel;
   port_mask_t port_clk_en;
   logic bus_fault;
   logic [2:0] fault_port;
   logic irq;
   int n_fail;
   int total_checks;
   logic [31:0] r;
   logic e;

   port_gate_ctrl dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
      .deep_sleep_active(deep_sleep_active), .port_acc_valid(port_acc_valid),
      .port_acc_sel(port_acc_sel), .port_clk_en(port_clk_en), .bus_fault(bus_fault),
      .fault_port(fault_port), .irq(irq)
   );

   always #10 pclk = ~pclk;

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task complete_run();
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The answer is taken at the rising edge at which pready is sampled high, and
   // only then is the request released.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd_data, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) n_fail++;
      rd_data = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
   endtask

   // Power state reaches port_clk_en two cycles after the input changes.
   task pw(input logic d, input logic s, input logic [7:0] x);
      @(posedge pclk);
      deep_sleep_active <= d;
      sleep_active <= s;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(32'(port_clk_en), 32'(x));
   endtask

   task acc(input logic [2:0] p, input logic exp);
      @(posedge pclk);
      port_acc_valid <= 1'b1;
      port_acc_sel <= p;
      @(posedge pclk);
      port_acc_valid <= 1'b0;
      @(negedge pclk);
      chk(32'(bus_fault), 32'(exp));
      if (exp) chk(32'(fault_port), 32'(p));
   endtask

   task irqchk(input logic x);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(32'(irq), 32'(x));
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      sleep_active = 1'b0;
      deep_sleep_active = 1'b0;
      port_acc_valid = 1'b0;
      port_acc_sel = 3'h0;
      n_fail = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`DEEP_PORT_GATE_OFF, 32'h0000_0000);
      rd(`RUN_CLOCK_CONFIG_OFF, 32'h0000_0000);
      wr(`RUN_PORT_GATE_OFF, 32'h0000_003C);
      wr(`SLEEP_PORT_GATE_OFF, 32'h0000_00C3);
      wr(`DEEP_PORT_GATE_OFF, 32'hFFFF_FF5A);
      apb(1'b0, `DEEP_PORT_GATE_OFF, 32'h0000_0000, r, e);
      chk(r & 32'hFFFF_FF00, 32'h0000_0000);
      wr(`DEEP_PORT_GATE_OFF, r);
      rd(`DEEP_PORT_GATE_OFF, 32'h0000_005A);
      rd(`RUN_PORT_GATE_OFF, 32'h0000_003C);
      rd(`SLEEP_PORT_GATE_OFF, 32'h0000_00C3);
      pw(1'b0, 1'b0, 8'h3C);
      pw(1'b1, 1'b0, 8'h3C);
      wr(`RUN_CLOCK_CONFIG_OFF, 32'h0800_0000);
      rd(`RUN_CLOCK_CONFIG_OFF, 32'h0800_0000);
      pw(1'b1, 1'b0, 8'h5A);
      // Every port is touched; 8'h5A is its own bit reversal, so a swapped bit order would not show up as a wrong fault.
      for (int i = 0; i < 8; i++) begin
         acc(i[2:0], ((8'h5A >> i) & 8'h01) == 8'h00);
      end
      pw(1'b0, 1'b1, 8'hC3);
      pw(1'b1, 1'b1, 8'h5A);
      pw(1'b0, 1'b0, 8'h3C);
      acc(3'h6, 1'b1);
      acc(3'h5, 1'b0);
      apb(1'b0, 12'h300, 32'h0000_0000, r, e);
      chk(32'(e), 32'h0000_0001);
      chk(r, 32'h0000_0000);
      rd(`INT_STATUS_OFF, 32'h0000_0003);
      wr(`INT_MASK_OFF, 32'h0000_0001);
      irqchk(1'b1);
      wr(`INT_STATUS_OFF, 32'h0000_0001);
      irqchk(1'b0);
      rd(`INT_STATUS_OFF, 32'h0000_0002);
      wr(`INT_MASK_OFF, 32'h0000_0002);
      irqchk(1'b1);
      wr(`INT_STATUS_OFF, 32'h0000_0002);
      irqchk(1'b0);
      rd(`INT_STATUS_OFF, 32'h0000_0000);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(32'(port_clk_en), 32'h0000_0000);
      rd(`DEEP_PORT_GATE_OFF, 32'h0000_0000);
      rd(`RUN_PORT_GATE_OFF, 32'h0000_0000);
      complete_run();
   end

   // The whole sequence takes well under a thousand cycles.
   initial begin
      #100_000;
      n_fail++;
      complete_run();
   end
endmodule
